// file: dv/mrie_prog_mem.sv
`default_nettype none

module mrie_prog_mem (
    input wire logic clk_sys, // Instruction clock
    input wire logic sys_rst, // Async reset
    input wire logic push, // Queue a word
    input wire logic [13:0] push_word, // Word to queue
    input wire logic slow, // Idle cycle after each take
    input wire logic instr_ready, // Executer can take
    output logic instr_valid, // Word presented
    output logic [13:0] instr_word, // Presented word
    output logic empty // Nothing queued or shown
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [13:0] words_q[$];
    logic show;

    // Present queued words, hold each until taken, scramble when idle
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            words_q.delete();
            instr_valid <= 1'b0;
            instr_word <= 14'h0000;
            empty <= 1'b1;
        end
        else
        begin
            if (push)
                words_q.push_back(push_word);
            show = instr_valid && !instr_ready;
            if (!show && words_q.size() > 0 && !(slow && instr_valid))
            begin
                instr_word <= words_q.pop_front();
                show = 1'b1;
            end
            else if (!show)
                instr_word <= ~instr_word;
            instr_valid <= show;
            empty <= !show && words_q.size() == 0;
        end
    end
endmodule : mrie_prog_mem

`default_nettype wire

// file: dv/testbench.sv
`default_nettype none
`include "mrie_params.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, sys_rst, push, slow, instr_valid, instr_ready, empty;
    logic [13:0] push_word, instr_word;
    logic [7:0] acc_in, prescale_cfg, m_cfg;
    logic [14:0] stack_top, program_counter, e_pc;
    logic [15:0] pointer_reg0, pointer_reg1, wr_addr, m_p0, m_p1, e_addr, base, nxt;
    logic wr_en, pc_load, stack_pop, global_irq_enable_set, soft_reset_req, soft_reset_flag_clr;
    logic e_chk, e_wr, e_pcl, e_rst;
    logic [7:0] wr_data, e_data;
    logic [6:0] dir_tab [8] = '{7'h00, 7'h04, 7'h05, 7'h01, 7'h06, 7'h07, 7'h20, 7'h7f};
    int n_errors, comparisons, cycles, t;

    mrie_exec u_mrie_exec (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .acc_in(acc_in), .stack_top(stack_top), .instr_ready(instr_ready),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .pointer_reg0(pointer_reg0),
        .pointer_reg1(pointer_reg1), .prescale_cfg(prescale_cfg), .pc_load(pc_load),
        .program_counter(program_counter), .stack_pop(stack_pop),
        .global_irq_enable_set(global_irq_enable_set), .soft_reset_req(soft_reset_req),
        .soft_reset_flag_clr(soft_reset_flag_clr));

    mrie_prog_mem u_mrie_prog_mem (.clk_sys(clk_sys), .sys_rst(sys_rst), .push(push),
        .push_word(push_word), .slow(slow), .instr_ready(instr_ready), .instr_valid(instr_valid),
        .instr_word(instr_word), .empty(empty));

    ////////////////////////////////////////////////////////////
    // Clock and timeout
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Rolling accumulator and stack values, cut a hang short
    always @(posedge clk_sys)
    begin
        acc_in <= acc_in + 8'h3b;
        stack_top <= stack_top + 15'h01a5;
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////
    // Reference model: check the cycle after each take, then predict
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            m_p0 = `MRIE_RST_PTR;
            m_p1 = `MRIE_RST_PTR;
            m_cfg = `MRIE_RST_CFG;
            e_chk = 1'b0;
        end
        else
        begin
            if (e_chk)
            begin
                `CHK("wr_en", e_wr, wr_en)
                if (e_wr)
                begin
                    `CHK("wr_addr", e_addr, wr_addr)
                    `CHK("wr_data", e_data, wr_data)
                end
                `CHK("pointer_reg0", m_p0, pointer_reg0)
                `CHK("pointer_reg1", m_p1, pointer_reg1)
                `CHK("prescale_cfg", m_cfg, prescale_cfg)
                `CHK("pc_load", e_pcl, pc_load)
                `CHK("stack_pop", e_pcl, stack_pop)
                if (e_pcl)
                    `CHK("program_counter", e_pc, program_counter)
                `CHK("irq_enable_set", e_pcl && e_data[0], global_irq_enable_set)
                `CHK("instr_ready", !e_pcl, instr_ready)
                `CHK("soft_reset_req", e_rst, soft_reset_req)
                `CHK("flag_clr", e_rst, soft_reset_flag_clr)
            end
            e_chk = instr_valid && instr_ready;
            if (e_chk)
            begin
                e_wr = 1'b0;
                e_pcl = 1'b0;
                e_rst = 1'b0;
                e_data = acc_in;
                e_pc = stack_top;
                base = instr_word[6] ? m_p1 : m_p0;
                if (instr_word == `MRIE_OP_SRST)
                    e_rst = 1'b1;
                else if (instr_word == `MRIE_OP_RET || instr_word == `MRIE_OP_RETI)
                begin
                    e_pcl = 1'b1;
                    e_data = {7'h00, instr_word[0]};
                end
                else if (instr_word == `MRIE_OP_CFG)
                    m_cfg = acc_in;
                else if (instr_word[13:7] == `MRIE_DIR_PREFIX)
                begin
                    e_wr = 1'b1;
                    e_addr = {9'h000, instr_word[6:0]};
                    if (instr_word[6:1] == 6'h00)
                        e_addr = instr_word[0] ? m_p1 : m_p0;
                    case (instr_word[6:0])
                        `MRIE_ADDR_P0_LO: m_p0[7:0] = acc_in;
                        `MRIE_ADDR_P0_HI: m_p0[15:8] = acc_in;
                        `MRIE_ADDR_P1_LO: m_p1[7:0] = acc_in;
                        `MRIE_ADDR_P1_HI: m_p1[15:8] = acc_in;
                        default: ;
                    endcase
                end
                else if (instr_word[13:3] == `MRIE_IND_PREFIX)
                begin
                    base = instr_word[2] ? m_p1 : m_p0;
                    nxt = instr_word[0] ? base - 16'h0001 : base + 16'h0001;
                    e_wr = 1'b1;
                    e_addr = instr_word[1] ? base : nxt;
                    if (instr_word[2])
                        m_p1 = nxt;
                    else
                        m_p0 = nxt;
                end
                else if (instr_word[13:7] == `MRIE_OFS_PREFIX)
                begin
                    e_wr = 1'b1;
                    e_addr = base + {{10{instr_word[5]}}, instr_word[5:0]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Queue one word in program memory
    task put(input logic [13:0] w);
        push <= 1'b1;
        push_word <= w;
        @(posedge clk_sys);
    endtask : put

    // Wait until every queued word has been taken
    task drain;
        push <= 1'b0;
        t = 0;
        repeat (2) @(posedge clk_sys);
        while (empty !== 1'b1 && t < 200)
        begin
            t++;
            @(posedge clk_sys);
        end
        // A queue that never empties counts as a mismatch
        if (empty !== 1'b1)
            n_errors++;
        repeat (3) @(posedge clk_sys);
    endtask : drain

    task complete_run;
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // Main sequence: fast pass, then slow pass, then soft reset
    initial
    begin
        sys_rst = 1'b1;
        push = 1'b0;
        push_word = 14'h0000;
        slow = 1'b0;
        acc_in = 8'h5a;
        stack_top = 15'h1234;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        `CHK("rst pointer_reg0", `MRIE_RST_PTR, pointer_reg0)
        `CHK("rst prescale_cfg", `MRIE_RST_CFG, prescale_cfg)
        for (int p = 0; p < 2; p++)
        begin
            slow <= p[0];
            for (int i = 0; i < 8; i++)
                put({`MRIE_IND_PREFIX, i[2], i[1:0] ^ 2'b01});
            for (int i = 0; i < 8; i++)
                put({`MRIE_DIR_PREFIX, dir_tab[i]});
            for (int i = 0; i < 4; i++)
                put({`MRIE_OFS_PREFIX, i[1], i[0] ? 6'h1f : 6'h20});
            put(`MRIE_OP_CFG);
            put(`MRIE_OP_IDLE);
            put(14'h0063);
            put(`MRIE_OP_RET);
            put({`MRIE_DIR_PREFIX, 7'h20});
            put(`MRIE_OP_RETI);
            put(`MRIE_OP_RETI);
            put(`MRIE_OP_CFG);
            drain();
        end
        put(`MRIE_OP_SRST);
        push <= 1'b0;
        t = 0;
        while (soft_reset_req !== 1'b1 && t < 20)
        begin
            t++;
            @(posedge clk_sys);
        end
        `CHK("srst request", 1'b1, soft_reset_req)
        sys_rst <= 1'b1;
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        `CHK("srst pointer_reg1", `MRIE_RST_PTR, pointer_reg1)
        `CHK("srst prescale_cfg", `MRIE_RST_CFG, prescale_cfg)
        complete_run();
    end
endmodule : testbench

`default_nettype wire

// file: src/mrie_exec.sv
// What this block does
// - Direct store copies accumulator to file address 0..127, one cycle, no flags.
// - Indirect store writes accumulator via pointer 0 or 1, code picks pre/post inc/dec.
// - Offset form addresses pointer plus signed -32..31, pointer unchanged.
// - Afterwards pointer is plus one, minus one, or unchanged for offset form.
// - Indirect port is not storage; access goes to pointer's address.
// - Pointers are 16 bits and wrap around both ways.
// - Pointer update and indirect store touch no status flag.
// - Config load copies accumulator to prescaler register, one cycle, no flags.
// - Software reset requests full device reset and clears soft reset flag.
// - Interrupt return pops stack into counter, sets global enable, two cycles.
// - Subroutine return pops stack into counter, two cycles, no flags.
`default_nettype none
`include "mrie_params.svh"

module mrie_exec (
    input wire logic clk_sys, // Core instruction clock
    input wire logic sys_rst, // Async reset, active high
    input wire logic instr_valid, // Instruction word present
    input wire logic [13:0] instr_word, // Word from program memory
    input wire logic [7:0] acc_in, // Accumulator value
    input wire logic [14:0] stack_top, // Top of hardware stack
    output logic instr_ready, // Ready to take a word
    output logic wr_en, // Data memory write strobe
    output logic [15:0] wr_addr, // Data memory write address
    output logic [7:0] wr_data, // Data memory write data
    output logic [15:0] pointer_reg0, // Pointer 0
    output logic [15:0] pointer_reg1, // Pointer 1
    output logic [7:0] prescale_cfg, // Prescaler configuration
    output logic pc_load, // Load program counter
    output logic [14:0] program_counter, // Value to load
    output logic stack_pop, // Pop hardware stack
    output logic global_irq_enable_set, // Set enable in irq control reg
    output logic soft_reset_req, // Start device reset
    output logic soft_reset_flag_clr // Clear flag in power control reg
);

    mrie_pkg::mrie_state_t st_q;
    mrie_pkg::mrie_state_t st_d;
    mrie_pkg::mrie_op_t op;
    mrie_ptr_if pif ();
    logic take;
    logic sel_ptr;
    logic [6:0] faddr;
    logic [15:0] sel_val;

    ////////////////////////////////////////////////////////////////////////
    // Decode

    assign take = instr_valid && st_q.ready;
    assign faddr = instr_word[6:0];

    // Classify the word
    always_comb
    begin
        op = mrie_pkg::MRIE_IDLE;
        if (instr_word == `MRIE_OP_SRST)
            op = mrie_pkg::MRIE_SRST;
        else if (instr_word == `MRIE_OP_RET)
            op = mrie_pkg::MRIE_RET;
        else if (instr_word == `MRIE_OP_RETI)
            op = mrie_pkg::MRIE_RETI;
        else if (instr_word == `MRIE_OP_CFG)
            op = mrie_pkg::MRIE_CFG;
        else if (instr_word[13:7] == `MRIE_DIR_PREFIX)
            op = mrie_pkg::MRIE_DIRECT;
        else if (instr_word[13:3] == `MRIE_IND_PREFIX)
            op = mrie_pkg::MRIE_INDIR;
        else if (instr_word[13:7] == `MRIE_OFS_PREFIX)
            op = mrie_pkg::MRIE_OFFS;
    end

    // Pointer select per form
    always_comb
    begin
        sel_ptr = 1'b0;
        unique case (op)
            mrie_pkg::MRIE_INDIR: sel_ptr = instr_word[2];
            mrie_pkg::MRIE_OFFS: sel_ptr = instr_word[6];
            mrie_pkg::MRIE_DIRECT: sel_ptr = (faddr == `MRIE_ADDR_IND1);
            default: sel_ptr = 1'b0;
        endcase
    end

    assign sel_val = sel_ptr ? st_q.ptr1 : st_q.ptr0;
    assign pif.ptr_val = sel_val;
    assign pif.addr_update_code = instr_word[1:0];
    assign pif.offset = instr_word[5:0];
    assign pif.offset_form = (op == mrie_pkg::MRIE_OFFS);

    mrie_ptr_unit u_ptr (
        .pif(pif.unit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        st_d = st_q;
        st_d.wr_en = 1'b0;
        st_d.pc_load = 1'b0;
        st_d.stack_pop = 1'b0;
        st_d.gie_set = 1'b0;
        st_d.rst_req = 1'b0;
        st_d.rflag_clr = 1'b0;
        st_d.ready = 1'b1;
        if (take)
        begin
            unique case (op)
                mrie_pkg::MRIE_IDLE:
                begin
                    st_d.ready = 1'b1;
                end
                mrie_pkg::MRIE_DIRECT:
                begin
                    st_d.wr_en = 1'b1;
                    st_d.wr_data = acc_in;
                    st_d.wr_addr = {9'h000, faddr};
                    if (faddr == `MRIE_ADDR_IND0 || faddr == `MRIE_ADDR_IND1)
                        st_d.wr_addr = sel_val;
                    if (faddr == `MRIE_ADDR_P0_LO)
                        st_d.ptr0[7:0] = acc_in;
                    if (faddr == `MRIE_ADDR_P0_HI)
                        st_d.ptr0[15:8] = acc_in;
                    if (faddr == `MRIE_ADDR_P1_LO)
                        st_d.ptr1[7:0] = acc_in;
                    if (faddr == `MRIE_ADDR_P1_HI)
                        st_d.ptr1[15:8] = acc_in;
                end
                mrie_pkg::MRIE_INDIR, mrie_pkg::MRIE_OFFS:
                begin
                    st_d.wr_en = 1'b1;
                    st_d.wr_data = acc_in;
                    st_d.wr_addr = pif.eff_addr;
                    if (sel_ptr)
                        st_d.ptr1 = pif.next_ptr;
                    else
                        st_d.ptr0 = pif.next_ptr;
                end
                mrie_pkg::MRIE_CFG:
                begin
                    st_d.prescale_cfg = acc_in;
                end
                mrie_pkg::MRIE_SRST:
                begin
                    st_d.rst_req = 1'b1;
                    st_d.rflag_clr = 1'b1;
                end
                mrie_pkg::MRIE_RET, mrie_pkg::MRIE_RETI:
                begin
                    // pop into counter, second cycle idle
                    st_d.stack_pop = 1'b1;
                    st_d.pc_load = 1'b1;
                    st_d.pc_val = stack_top;
                    st_d.ready = 1'b0;
                    st_d.gie_set = (op == mrie_pkg::MRIE_RETI);
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q.ptr0 <= `MRIE_RST_PTR;
            st_q.ptr1 <= `MRIE_RST_PTR;
            st_q.prescale_cfg <= `MRIE_RST_CFG;
            st_q.wr_en <= 1'b0;
            st_q.wr_addr <= 16'h0000;
            st_q.wr_data <= 8'h00;
            st_q.pc_load <= 1'b0;
            st_q.pc_val <= `MRIE_RST_PC;
            st_q.stack_pop <= 1'b0;
            st_q.gie_set <= 1'b0;
            st_q.rst_req <= 1'b0;
            st_q.rflag_clr <= 1'b0;
            st_q.ready <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign instr_ready = st_q.ready;
    assign wr_en = st_q.wr_en;
    assign wr_addr = st_q.wr_addr;
    assign wr_data = st_q.wr_data;
    assign pointer_reg0 = st_q.ptr0;
    assign pointer_reg1 = st_q.ptr1;
    assign prescale_cfg = st_q.prescale_cfg;
    assign pc_load = st_q.pc_load;
    assign program_counter = st_q.pc_val;
    assign stack_pop = st_q.stack_pop;
    assign global_irq_enable_set = st_q.gie_set;
    assign soft_reset_req = st_q.rst_req;
    assign soft_reset_flag_clr = st_q.rflag_clr;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    direct_store_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == mrie_pkg::MRIE_DIRECT && faddr > 7'h01
        |=> wr_en && wr_addr == {9'h000, $past(faddr)} && wr_data == $past(acc_in))
        else $error("direct store wrong");

    indir_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == mrie_pkg::MRIE_INDIR && instr_word[1:0] == 2'h0
        |=> wr_en && wr_addr == $past(sel_val) + 16'h0001)
        else $error("pre-increment address wrong");

    offs_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == mrie_pkg::MRIE_OFFS
        |=> $stable(pointer_reg0) && $stable(pointer_reg1))
        else $error("offset form moved a pointer");

    ptr_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == mrie_pkg::MRIE_INDIR && !instr_word[2] && instr_word[0]
        |=> pointer_reg0 == $past(pointer_reg0) - 16'h0001)
        else $error("decrement did not step pointer");

    port_redirect_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == mrie_pkg::MRIE_DIRECT && faddr == 7'h01
        |=> wr_addr == $past(pointer_reg1))
        else $error("indirect port not redirected");

    cfg_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == mrie_pkg::MRIE_CFG |=> prescale_cfg == $past(acc_in) && !wr_en)
        else $error("prescaler load wrong");

    soft_reset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        soft_reset_req |-> soft_reset_flag_clr && $past(take))
        else $error("reset request without flag clear");

    irq_return_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == mrie_pkg::MRIE_RETI
        |=> pc_load && global_irq_enable_set && !instr_ready ##1 instr_ready && !pc_load)
        else $error("interrupt return wrong");

    sub_return_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == mrie_pkg::MRIE_RET
        |=> stack_pop && program_counter == $past(stack_top) && !global_irq_enable_set)
        else $error("subroutine return wrong");

endmodule : mrie_exec

`default_nettype wire

// file: src/mrie_params.svh
`ifndef MRIE_PARAMS_SVH
`define MRIE_PARAMS_SVH

// Instruction encodings, 14-bit words
`define MRIE_OP_IDLE 14'h0000
`define MRIE_OP_SRST 14'h0001
`define MRIE_OP_RET 14'h0008
`define MRIE_OP_RETI 14'h0009
`define MRIE_OP_CFG 14'h0062
// Direct store: word[13:7] matches, word[6:0] is the file address
`define MRIE_DIR_PREFIX 7'h01
// Indirect store: word[13:3] matches, word[2] pointer, word[1:0] update code
`define MRIE_IND_PREFIX 11'h003
// Offset store: word[13:7] matches, word[6] pointer, word[5:0] signed offset
`define MRIE_OFS_PREFIX 7'h7f

// File addresses of the indirect ports and the pointer bytes
`define MRIE_ADDR_IND0 7'h00
`define MRIE_ADDR_IND1 7'h01
`define MRIE_ADDR_P0_LO 7'h04
`define MRIE_ADDR_P0_HI 7'h05
`define MRIE_ADDR_P1_LO 7'h06
`define MRIE_ADDR_P1_HI 7'h07

// Reset values
`define MRIE_RST_PTR 16'h0000
`define MRIE_RST_CFG 8'hff
`define MRIE_RST_PC 15'h0000

// Update codes
`define MRIE_UPD_PRE_INC 2'h0
`define MRIE_UPD_PRE_DEC 2'h1
`define MRIE_UPD_POST_INC 2'h2
`define MRIE_UPD_POST_DEC 2'h3

`endif

// file: src/mrie_pkg.sv
`default_nettype none

package mrie_pkg;

    // Decoded instruction group
    typedef enum logic [2:0] {
        MRIE_IDLE = 3'b000,
        MRIE_DIRECT = 3'b001,
        MRIE_INDIR = 3'b010,
        MRIE_OFFS = 3'b011,
        MRIE_CFG = 3'b100,
        MRIE_SRST = 3'b101,
        MRIE_RET = 3'b110,
        MRIE_RETI = 3'b111
    } mrie_op_t;

    // Whole state of the executer
    typedef struct packed {
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [7:0] prescale_cfg;
        logic wr_en;
        logic [15:0] wr_addr;
        logic [7:0] wr_data;
        logic pc_load;
        logic [14:0] pc_val;
        logic stack_pop;
        logic gie_set;
        logic rst_req;
        logic rflag_clr;
        logic ready;
    } mrie_state_t;

endpackage : mrie_pkg

`default_nettype wire

// file: src/mrie_ptr_if.sv
`default_nettype none

interface mrie_ptr_if;
    logic [15:0] ptr_val;
    logic [1:0] addr_update_code;
    logic [5:0] offset;
    logic offset_form;
    logic [15:0] eff_addr;
    logic [15:0] next_ptr;

    modport unit (input ptr_val, addr_update_code, offset, offset_form, output eff_addr, next_ptr);
    modport core (output ptr_val, addr_update_code, offset, offset_form, input eff_addr, next_ptr);
endinterface : mrie_ptr_if

`default_nettype wire

// file: src/mrie_ptr_unit.sv
`default_nettype none
`include "mrie_params.svh"

module mrie_ptr_unit (
    mrie_ptr_if.unit pif // Pointer arithmetic request
);

    logic [15:0] ofs_ext;
    logic [15:0] inc_val;
    logic [15:0] dec_val;

    // Sign extension and 16-bit wrapping neighbours
    assign ofs_ext = {{10{pif.offset[5]}}, pif.offset};
    assign inc_val = pif.ptr_val + 16'h0001;
    assign dec_val = pif.ptr_val - 16'h0001;

    // Effective address and pointer after the store
    always_comb
    begin
        pif.eff_addr = pif.ptr_val;
        pif.next_ptr = pif.ptr_val;
        if (pif.offset_form)
        begin
            pif.eff_addr = pif.ptr_val + ofs_ext;
        end
        else
        begin
            unique case (pif.addr_update_code)
                `MRIE_UPD_PRE_INC: pif.eff_addr = inc_val;
                `MRIE_UPD_PRE_DEC: pif.eff_addr = dec_val;
                `MRIE_UPD_POST_INC: pif.eff_addr = pif.ptr_val;
                `MRIE_UPD_POST_DEC: pif.eff_addr = pif.ptr_val;
            endcase
            pif.next_ptr = pif.addr_update_code[0] ? dec_val : inc_val;
        end
    end

endmodule : mrie_ptr_unit

`default_nettype wire
